/* logic/ifb_flag_bank.sv */
// interrupt request flag and enable bank with an AXI4-Lite register slave
`timescale 1ns/100ps

module ifb_flag_bank (
  input  wire logic                       aclk,                // system clock, 125 MHz
  input  wire logic                       aresetn,             // synchronous reset, low
  input  wire logic [ifb_pkg::ADDR_W-1:0] s_axi_awaddr,        // write address
  input  wire logic                       s_axi_awvalid,       // write address valid
  output logic                            s_axi_awready,       // write address ready
  input  wire logic [31:0]                s_axi_wdata,         // write data
  input  wire logic [3:0]                 s_axi_wstrb,         // write byte strobes
  input  wire logic                       s_axi_wvalid,        // write data valid
  output logic                            s_axi_wready,        // write data ready
  output logic [1:0]                      s_axi_bresp,         // write response
  output logic                            s_axi_bvalid,        // write response valid
  input  wire logic                       s_axi_bready,        // write response ready
  input  wire logic [ifb_pkg::ADDR_W-1:0] s_axi_araddr,        // read address
  input  wire logic                       s_axi_arvalid,       // read address valid
  output logic                            s_axi_arready,       // read address ready
  output logic [31:0]                     s_axi_rdata,         // read data
  output logic [1:0]                      s_axi_rresp,         // read response
  output logic                            s_axi_rvalid,        // read data valid
  input  wire logic                       s_axi_rready,        // read data ready
  input  wire logic                       ext_pin_b,           // external pin b, asynchronous
  input  wire logic                       ext_pin_c,           // external pin c, asynchronous
  input  wire logic                       group4_pending,      // group four request level
  input  wire logic                       serial_event,        // serial port event pulse
  input  wire logic                       timer_a_cmpa_match,  // timer a comparator a pulse
  input  wire logic                       timer_a_cmpp_match,  // timer a comparator p pulse
  input  wire logic                       timer_b_cmpa_match,  // timer b comparator a pulse
  input  wire logic                       timer_b_cmpp_match,  // timer b comparator p pulse
  output logic                            cpu_irq_req,         // service request to the core
  output logic                            irq                  // masked event interrupt level
);
  import ifb_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                aw_held_ff, nxt_aw_held;
  logic [ADDR_W-1:0]   aw_addr_ff, nxt_aw_addr;
  logic                w_held_ff,  nxt_w_held;
  logic [7:0]          w_data_ff,  nxt_w_data;
  logic                w_strb_ff,  nxt_w_strb;
  logic                bvalid_ff,  nxt_bvalid;
  logic [1:0]          bresp_ff,   nxt_bresp;
  logic                rvalid_ff,  nxt_rvalid;
  logic [7:0]          rdata_ff,   nxt_rdata;
  logic [1:0]          rresp_ff,   nxt_rresp;

  logic [7:0]          ctrl_ff,    nxt_ctrl;
  logic [7:0]          tmr_a_ff,   nxt_tmr_a;
  logic [7:0]          tmr_b_ff,   nxt_tmr_b;
  logic [7:0]          edge_ff,    nxt_edge;
  logic                gen_ff,     nxt_gen;
  logic [7:0]          ev_stat_ff, nxt_ev_stat;
  logic [7:0]          ev_mask_ff, nxt_ev_mask;

  logic [2:0]          pin_b_ff,   nxt_pin_b;
  logic [2:0]          pin_c_ff,   nxt_pin_c;
  logic                grp4_d_ff,  nxt_grp4_d;

  logic                do_wr;
  logic                wr_ok;
  logic [7:0]          wbyte;
  logic                pin_b_qual;
  logic                pin_c_qual;
  logic                grp4_rise;
  logic [7:0]          ev_now;
  logic [7:0]          rd_val;
  logic                rd_hit;

  // ----------------------------------------------------------------
  // edge qualification
  // ----------------------------------------------------------------
  // decode one edge select field against the synchronised pin history
  function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic old);
    logic rise;
    logic fall;
    rise = now & ~old;
    fall = ~now & old;
    case (sel)
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
      default:   edge_hit = 1'b0;
    endcase
  endfunction

  // stage 0 only feeds stage 1; edges are taken between stages 1 and 2
  assign pin_b_qual = edge_hit(edge_ff[PIN_B_SEL_LSB +: 2], pin_b_ff[1], pin_b_ff[2]); // see R12
  assign pin_c_qual = edge_hit(edge_ff[PIN_C_SEL_LSB +: 2], pin_c_ff[1], pin_c_ff[2]); // see R12
  assign grp4_rise  = group4_pending & ~grp4_d_ff;

  // events feeding the sticky status word
  always_comb begin
    ev_now           = 8'h00;
    ev_now[EV_PIN_B] = pin_b_qual;
    ev_now[EV_PIN_C] = pin_c_qual;
    ev_now[EV_GRP4]  = grp4_rise;
    ev_now[EV_SER]   = serial_event;
    ev_now[EV_TA_A]  = timer_a_cmpa_match;
    ev_now[EV_TA_P]  = timer_a_cmpp_match;
    ev_now[EV_TB_A]  = timer_b_cmpa_match;
    ev_now[EV_TB_P]  = timer_b_cmpp_match;
  end

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // no new address or data is taken while a response waits, so one write is in flight
  assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = {24'h000000, rdata_ff};

  assign do_wr = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wr_ok = do_wr & w_strb_ff; // data sits in byte lane 0 only
  assign wbyte = w_data_ff;

  // read mux, reserved bits come out as zero
  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFS_CTRL_BANK: rd_val = ctrl_ff;
      OFS_TMR_A:     rd_val = tmr_a_ff & TMR_IMPL_MASK; // see R11
      OFS_TMR_B:     rd_val = tmr_b_ff & TMR_IMPL_MASK; // see R11
      OFS_EDGE_SEL:  rd_val = edge_ff & EDGE_IMPL_MASK;
      OFS_GLOBAL:    rd_val = {7'h00, gen_ff};
      OFS_EV_STAT:   rd_val = ev_stat_ff;
      OFS_EV_MASK:   rd_val = ev_mask_ff;
      default:       rd_hit = 1'b0;
    endcase
  end

  // next values of the bus channels
  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_held  = w_held_ff;
    nxt_w_data  = w_data_ff;
    nxt_w_strb  = w_strb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_held = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_held = 1'b1;
      nxt_w_data = s_axi_wdata[7:0];
      nxt_w_strb = s_axi_wstrb[0];
    end
    if (do_wr) begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      case (aw_addr_ff)
        OFS_CTRL_BANK, OFS_TMR_A, OFS_TMR_B, OFS_EDGE_SEL,
        OFS_GLOBAL, OFS_EV_STAT, OFS_EV_MASK: nxt_bresp = RESP_OKAY;
        default:                              nxt_bresp = RESP_SLV;
      endcase
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = rd_val;
      nxt_rresp  = rd_hit ? RESP_OKAY : RESP_SLV;
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_held_ff  <= 1'b0;
      w_data_ff  <= 8'h00;
      w_strb_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 8'h00;
      rresp_ff   <= RESP_OKAY;
    end else begin
      aw_held_ff <= nxt_aw_held;
      aw_addr_ff <= nxt_aw_addr;
      w_held_ff  <= nxt_w_held;
      w_data_ff  <= nxt_w_data;
      w_strb_ff  <= nxt_w_strb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  // ----------------------------------------------------------------
  // flag and enable registers
  // ----------------------------------------------------------------
  // a hardware set in the same cycle as a software write of zero still wins
  always_comb begin
    nxt_pin_b   = {pin_b_ff[1:0], ext_pin_b};
    nxt_pin_c   = {pin_c_ff[1:0], ext_pin_c};
    nxt_grp4_d  = group4_pending;
    nxt_ctrl    = ctrl_ff;
    nxt_tmr_a   = tmr_a_ff;
    nxt_tmr_b   = tmr_b_ff;
    nxt_edge    = edge_ff;
    nxt_gen     = gen_ff;
    nxt_ev_mask = ev_mask_ff;
    nxt_ev_stat = ev_stat_ff;
    if (wr_ok) begin
      case (aw_addr_ff)
        OFS_CTRL_BANK: nxt_ctrl    = wbyte;                    // see R4
        OFS_TMR_A:     nxt_tmr_a   = wbyte & TMR_IMPL_MASK;    // see R6, R11, R13
        OFS_TMR_B:     nxt_tmr_b   = wbyte & TMR_IMPL_MASK;    // see R9, R10, R11
        OFS_EDGE_SEL:  nxt_edge    = wbyte & EDGE_IMPL_MASK;   // see R12
        OFS_GLOBAL:    nxt_gen     = wbyte[GLOBAL_EN_BIT];
        OFS_EV_STAT:   nxt_ev_stat = ev_stat_ff & ~wbyte;
        OFS_EV_MASK:   nxt_ev_mask = wbyte;
        default:       nxt_gen     = gen_ff;
      endcase
    end
    // the group flag follows a pending level, so a clear is retaken while it stays high
    if (group4_pending) nxt_ctrl[GRP4_FLAG_BIT] = 1'b1;          // see R1
    if (pin_c_qual) nxt_ctrl[PIN_C_FLAG_BIT] = 1'b1;             // see R2
    if (pin_b_qual) nxt_ctrl[PIN_B_FLAG_BIT] = 1'b1;             // see R3
    if (serial_event) nxt_ctrl[SER_FLAG_BIT] = 1'b1;
    if (timer_a_cmpa_match) nxt_tmr_a[CMPA_FLAG_BIT] = 1'b1;     // see R5
    if (timer_a_cmpp_match) nxt_tmr_a[CMPP_FLAG_BIT] = 1'b1;     // see R13
    if (timer_b_cmpa_match) nxt_tmr_b[CMPA_FLAG_BIT] = 1'b1;     // see R7
    if (timer_b_cmpp_match) nxt_tmr_b[CMPP_FLAG_BIT] = 1'b1;     // see R8
    nxt_ev_stat = nxt_ev_stat | ev_now;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_b_ff   <= 3'h0;
      pin_c_ff   <= 3'h0;
      grp4_d_ff  <= 1'b0;
      ctrl_ff    <= REG_RESET;
      tmr_a_ff   <= REG_RESET;
      tmr_b_ff   <= REG_RESET;
      edge_ff    <= REG_RESET;
      gen_ff     <= 1'b0;
      ev_stat_ff <= REG_RESET;
      ev_mask_ff <= REG_RESET;
    end else begin
      pin_b_ff   <= nxt_pin_b;
      pin_c_ff   <= nxt_pin_c;
      grp4_d_ff  <= nxt_grp4_d;
      ctrl_ff    <= nxt_ctrl;
      tmr_a_ff   <= nxt_tmr_a;
      tmr_b_ff   <= nxt_tmr_b;
      edge_ff    <= nxt_edge;
      gen_ff     <= nxt_gen;
      ev_stat_ff <= nxt_ev_stat;
      ev_mask_ff <= nxt_ev_mask;
    end
  end

  // ----------------------------------------------------------------
  // interrupt outputs
  // ----------------------------------------------------------------
  // service request: any flag with its enable, gated by the global enable
  assign cpu_irq_req = gen_ff & (                                                 // see R14
                       (ctrl_ff[GRP4_FLAG_BIT]  & ctrl_ff[GRP4_EN_BIT])  |
                       (ctrl_ff[PIN_C_FLAG_BIT] & ctrl_ff[PIN_C_EN_BIT]) |        // see R4
                       (ctrl_ff[PIN_B_FLAG_BIT] & ctrl_ff[PIN_B_EN_BIT]) |        // see R4
                       (ctrl_ff[SER_FLAG_BIT]   & ctrl_ff[SER_EN_BIT])   |
                       (tmr_a_ff[CMPA_FLAG_BIT] & tmr_a_ff[CMPA_EN_BIT]) |        // see R6
                       (tmr_a_ff[CMPP_FLAG_BIT] & tmr_a_ff[CMPP_EN_BIT]) |        // see R13
                       (tmr_b_ff[CMPA_FLAG_BIT] & tmr_b_ff[CMPA_EN_BIT]) |        // see R9
                       (tmr_b_ff[CMPP_FLAG_BIT] & tmr_b_ff[CMPP_EN_BIT]));        // see R10

  // event interrupt: sticky status gated by the mask, independent of the global enable
  assign irq = |(ev_stat_ff & ev_mask_ff);

endmodule // ifb_flag_bank

/* logic/ifb_pkg.sv */
// package with register map, field positions and codes of the interrupt flag/enable bank
//
// Function
// R1: bit 7 of the control bank register is the group-four request flag, 1 while a request pends.
// R2: bit 6 of the control bank register sets on a qualifying edge of external pin c.
// R3: bit 5 of the control bank register sets on a qualifying edge of external pin b.
// R4: bits 2 and 1 of the control bank register enable the pin c and pin b interrupts.
// R5: bit 5 of the timer a register sets when timer a comparator a matches.
// R6: bit 1 of the timer a register enables the timer a comparator a interrupt.
// R7: bit 5 of the timer b register sets when timer b comparator a matches.
// R8: bit 4 of the timer b register sets when timer b comparator p matches.
// R9: bit 1 of the timer b register enables the timer b comparator a interrupt.
// R10: bit 0 of the timer b register enables the timer b comparator p interrupt.
// R11: bits 7..6 and 3..2 of both timer registers are unimplemented and read as zero.
// R12: a two-bit edge select gives 00 off, 01 rising, 10 falling, 11 both edges.
// R13: timer a comparator p uses bit 4 as flag and bit 0 as enable like timer b.
// R14: a source requests service only while its flag, its enable and the global enable are 1.
package ifb_pkg;

  // ----------------------------------------------------------------
  // bus geometry and responses
  // ----------------------------------------------------------------
  localparam int         ADDR_W    = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLV  = 2'h2;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL_BANK = 8'h00; // irq_ctrl_bank_two
  localparam logic [ADDR_W-1:0] OFS_TMR_A     = 8'h04; // timer0_match_irq
  localparam logic [ADDR_W-1:0] OFS_TMR_B     = 8'h08; // timer1_match_irq
  localparam logic [ADDR_W-1:0] OFS_EDGE_SEL  = 8'h0c; // edge_select_register
  localparam logic [ADDR_W-1:0] OFS_GLOBAL    = 8'h10; // global_irq_enable
  localparam logic [ADDR_W-1:0] OFS_EV_STAT   = 8'h14; // sticky event status, write one to clear
  localparam logic [ADDR_W-1:0] OFS_EV_MASK   = 8'h18; // event mask

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int GRP4_FLAG_BIT   = 7;
  localparam int PIN_C_FLAG_BIT  = 6;
  localparam int PIN_B_FLAG_BIT  = 5;
  localparam int SER_FLAG_BIT    = 4;
  localparam int GRP4_EN_BIT     = 3;
  localparam int PIN_C_EN_BIT    = 2;
  localparam int PIN_B_EN_BIT    = 1;
  localparam int SER_EN_BIT      = 0;
  localparam int CMPA_FLAG_BIT   = 5;
  localparam int CMPP_FLAG_BIT   = 4;
  localparam int CMPA_EN_BIT     = 1;
  localparam int CMPP_EN_BIT     = 0;
  localparam int PIN_C_SEL_LSB   = 6;
  localparam int PIN_B_SEL_LSB   = 4;
  localparam int GLOBAL_EN_BIT   = 0;

  // implemented bits of the timer and edge select registers
  localparam logic [7:0] TMR_IMPL_MASK  = 8'h33;
  localparam logic [7:0] EDGE_IMPL_MASK = 8'hf0;

  // event status bit positions
  localparam int EV_PIN_B = 0;
  localparam int EV_PIN_C = 1;
  localparam int EV_GRP4  = 2;
  localparam int EV_SER   = 3;
  localparam int EV_TA_A  = 4;
  localparam int EV_TA_P  = 5;
  localparam int EV_TB_A  = 6;
  localparam int EV_TB_P  = 7;

  // ----------------------------------------------------------------
  // reset values and edge select codes
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

endpackage : ifb_pkg

/* tb/ifb_flag_bank_props.sv */
// checker of bus timing and interrupt causes at the flag bank ports
`timescale 1ns/100ps
module ifb_flag_bank_props
  import ifb_pkg::*;
(
  input wire logic        aclk,               // clock
  input wire logic        aresetn,            // reset, low
  input wire logic        s_axi_awvalid,      // write address valid
  input wire logic        s_axi_awready,      // write address ready
  input wire logic        s_axi_wvalid,       // write data valid
  input wire logic        s_axi_wready,       // write data ready
  input wire logic [1:0]  s_axi_bresp,        // write response
  input wire logic        s_axi_bvalid,       // write response valid
  input wire logic        s_axi_bready,       // write response ready
  input wire logic        s_axi_arvalid,      // read address valid
  input wire logic        s_axi_arready,      // read address ready
  input wire logic [31:0] s_axi_rdata,        // read data
  input wire logic [1:0]  s_axi_rresp,        // read response
  input wire logic        s_axi_rvalid,       // read data valid
  input wire logic        s_axi_rready,       // read data ready
  input wire logic        ext_pin_b,          // pin b
  input wire logic        ext_pin_c,          // pin c
  input wire logic        group4_pending,     // group four level
  input wire logic        serial_event,       // serial pulse
  input wire logic        timer_a_cmpa_match, // timer a cmp a
  input wire logic        timer_a_cmpp_match, // timer a cmp p
  input wire logic        timer_b_cmpa_match, // timer b cmp a
  input wire logic        timer_b_cmpp_match, // timer b cmp p
  input wire logic        cpu_irq_req,        // core request
  input wire logic        irq                 // event interrupt
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic ev_any;
  // any same-clock event; pins are looked at through a window since sync adds delay
  assign ev_any = group4_pending | serial_event | timer_a_cmpa_match | timer_a_cmpp_match
                | timer_b_cmpa_match | timer_b_cmpp_match;
  // ----------------------------------------------------------------
  // bus channel and interrupt cause sequences
  // ----------------------------------------------------------------
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_cause;
    $rose(s_axi_bvalid) || $past(ev_any) || ($past(ext_pin_b, 2) != $past(ext_pin_b, 5))
      || ($past(ext_pin_c, 2) != $past(ext_pin_c, 5));
  endsequence
  a_wr_latency: assert property (s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two cycles after accept");
  a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not one cycle after accept");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped before taken");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before taken");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready && 1'b1)
    else $error("write accepted while answer pending");
  a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  a_byte_lane: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bytes not zero");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLV |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  a_req_cause: assert property ($rose(cpu_irq_req) |-> s_cause)
    else $error("core request rose without cause");
  a_irq_cause: assert property ($rose(irq) |-> s_cause)
    else $error("interrupt rose without cause");
  a_reset_idle: assert property (!$past(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq
                                 && !cpu_irq_req)
    else $error("outputs active after reset");
endmodule // ifb_flag_bank_props

bind ifb_flag_bank ifb_flag_bank_props ifb_flag_bank_props_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ext_pin_b(ext_pin_b),
  .ext_pin_c(ext_pin_c), .group4_pending(group4_pending), .serial_event(serial_event),
  .timer_a_cmpa_match(timer_a_cmpa_match), .timer_a_cmpp_match(timer_a_cmpp_match),
  .timer_b_cmpa_match(timer_b_cmpa_match), .timer_b_cmpp_match(timer_b_cmpp_match),
  .cpu_irq_req(cpu_irq_req), .irq(irq));

/* tb/ifb_event_src.sv */
// model of the peripheral event sources beside the flag bank
`timescale 1ns/100ps
module ifb_event_src (
  input  wire logic aclk,               // clock
  output logic      ext_pin_b,          // pin b level
  output logic      ext_pin_c,          // pin c level
  output logic      group4_pending,     // group four level
  output logic      serial_event,       // serial pulse
  output logic      timer_a_cmpa_match, // timer a cmp a pulse
  output logic      timer_a_cmpp_match, // timer a cmp p pulse
  output logic      timer_b_cmpa_match, // timer b cmp a pulse
  output logic      timer_b_cmpp_match  // timer b cmp p pulse
);
  logic [7:0] pulse_ff = 8'h00;
  logic [2:0] lvl_ff   = 3'h0;
  // pulses last exactly one clock, as a timer match does
  assign {timer_b_cmpp_match, timer_b_cmpa_match, timer_a_cmpp_match, timer_a_cmpa_match,
          serial_event} = pulse_ff[4:0];
  assign {group4_pending, ext_pin_c, ext_pin_b} = lvl_ff;
  // one-clock pulse on source k: 0 serial, 1 ta a, 2 ta p, 3 tb a, 4 tb p
  task automatic fire(input int k);
    @(posedge aclk);
    pulse_ff <= 8'h01 << k;
    @(posedge aclk);
    pulse_ff <= 8'h00;
  endtask
  // levels {group4, pin c, pin b} change right after an edge
  task automatic level(input logic [2:0] v);
    @(posedge aclk);
    lvl_ff <= v;
  endtask
endmodule // ifb_event_src

/* tb/ifb_flag_bank_bench.sv */
// self-checking bench of the interrupt flag bank
`timescale 1ns/100ps
module ifb_flag_bank_bench;
  import ifb_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        pb, pc, g4, ser, taa, tap, tba, tbp, cpu_irq_req, irq;
  int          errors = 0, n_tests = 0, cyc = 0;
  ifb_flag_bank ifb_flag_bank_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ext_pin_b(pb), .ext_pin_c(pc), .group4_pending(g4),
    .serial_event(ser), .timer_a_cmpa_match(taa), .timer_a_cmpp_match(tap),
    .timer_b_cmpa_match(tba), .timer_b_cmpp_match(tbp), .cpu_irq_req, .irq);
  ifb_event_src ifb_event_src_i (.aclk, .ext_pin_b(pb), .ext_pin_c(pc), .group4_pending(g4),
    .serial_event(ser), .timer_a_cmpa_match(taa), .timer_a_cmpp_match(tap),
    .timer_b_cmpa_match(tba), .timer_b_cmpp_match(tbp));
  always #4 aclk = ~aclk;
  // watchdog: the whole sequence needs well under 5000 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // readies are looked at mid-cycle, where nothing is switching
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic pa, pw, ha, hw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (pa || pw) begin
      @(negedge aclk);
      ha = s_axi_awready;
      hw = s_axi_wready;
      @(posedge aclk);
      if (pa && ha) s_axi_awvalid <= 1'b0;
      if (pw && hw) s_axi_wvalid <= 1'b0;
      pa = pa && !ha;
      pw = pw && !hw;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    chk(s_axi_bresp, er);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    @(negedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    chk(s_axi_rresp, er);
    chk(s_axi_rdata, {24'h0, exp});
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(8'(i * 4), REG_RESET);
    rd(8'h1c, 8'h00, RESP_SLV);
    wr(8'h1c, 8'hff, RESP_SLV);
    wr(OFS_TMR_A, 8'hff);
    rd(OFS_TMR_A, TMR_IMPL_MASK);
    wr(OFS_TMR_B, 8'hff);
    rd(OFS_TMR_B, TMR_IMPL_MASK);
    wr(OFS_CTRL_BANK, 8'hff);
    rd(OFS_CTRL_BANK, 8'hff);
    wr(OFS_TMR_A, 8'h00);
    wr(OFS_TMR_B, 8'h00);
    wr(OFS_CTRL_BANK, 8'h00);
    // each comparator match sets its own flag and no other
    for (int k = 1; k < 5; k++) begin
      ifb_event_src_i.fire(k);
      rd(OFS_TMR_A, k == 1 ? 8'h20 : k == 2 ? 8'h30 : 8'h30);
      rd(OFS_TMR_B, k == 3 ? 8'h20 : k == 4 ? 8'h30 : 8'h00);
    end
    // enables and global enable gate the core request
    wr(OFS_TMR_A, 8'h00);
    wr(OFS_TMR_B, 8'h11);
    chk(cpu_irq_req, 1'b0);
    wr(OFS_GLOBAL, 8'h01);
    chk(cpu_irq_req, 1'b1);
    wr(OFS_TMR_B, 8'h21);
    chk(cpu_irq_req, 1'b0);
    wr(OFS_TMR_B, 8'h22);
    chk(cpu_irq_req, 1'b1);
    wr(OFS_TMR_A, 8'h11);
    wr(OFS_TMR_B, 8'h00);
    chk(cpu_irq_req, 1'b1);
    wr(OFS_TMR_A, 8'h22);
    chk(cpu_irq_req, 1'b1);
    wr(OFS_TMR_A, 8'h00);
    wr(OFS_CTRL_BANK, 8'h44);
    chk(cpu_irq_req, 1'b1);
    wr(OFS_CTRL_BANK, 8'h40);
    chk(cpu_irq_req, 1'b0);
    wr(OFS_CTRL_BANK, 8'h00);
    // every edge select code on both pins, rising then falling
    for (int c = 0; c < 4; c++) begin
      wr(OFS_EDGE_SEL, {2'(c), 2'(c), 4'h0});
      ifb_event_src_i.level(3'b011);
      repeat (5) @(posedge aclk);
      rd(OFS_CTRL_BANK, c[0] ? 8'h60 : 8'h00);
      wr(OFS_CTRL_BANK, 8'h00);
      ifb_event_src_i.level(3'b000);
      repeat (5) @(posedge aclk);
      rd(OFS_CTRL_BANK, c[1] ? 8'h60 : 8'h00);
      wr(OFS_CTRL_BANK, 8'h00);
    end
    // group four flag follows the pending level
    ifb_event_src_i.level(3'b100);
    wr(OFS_CTRL_BANK, 8'h00);
    rd(OFS_CTRL_BANK, 8'h80);
    ifb_event_src_i.level(3'b000);
    wr(OFS_CTRL_BANK, 8'h00);
    rd(OFS_CTRL_BANK, 8'h00);
    // sticky status, mask and write-one-to-clear
    wr(OFS_EV_STAT, 8'hff);
    wr(OFS_EV_MASK, 8'h00);
    ifb_event_src_i.fire(4);
    rd(OFS_EV_STAT, 8'h80);
    chk(irq, 1'b0);
    wr(OFS_EV_MASK, 8'h80);
    chk(irq, 1'b1);
    wr(OFS_EV_STAT, 8'h80);
    chk(irq, 1'b0);
    rd(OFS_EV_STAT, 8'h00);
    results();
  end
endmodule // ifb_flag_bank_bench
